// ---- rtl/difl_core.sv ----
// Drive input function logic: three-wire run control, process-loop
// enable and clear, speed-loop gain set and P/PI selection with droop.
// Assumes terminal levels arrive from pins and parameters are static
// levels on the system clock.
`timescale 1ns/100ps
module difl_core
    import difl_pkg::*;
(
    // Clock and reset
    input  wire logic                           clk_in,
    input  wire logic                           rst_in,
    // Terminals
    input  wire logic [DIFL_TERMS-1:0]          term_in,
    input  wire logic                           forward_run_input_in,
    input  wire logic [DIFL_TERMS-1:0][5:0]     term_func_in,
    // Drive parameters
    input  wire logic [1:0]                     run_source_select_in,
    input  wire logic [1:0]                     loop_enable_param_in,
    input  wire logic [2:0]                     control_method_select_in,
    input  wire logic                           second_motor_in,
    input  wire logic [9:0]                     primary_p_gain_in,
    input  wire logic [9:0]                     second_p_gain_in,
    input  wire logic [9:0]                     alternate_p_gain_in,
    // Run control
    output logic                                run_out,
    output logic                                reverse_out,
    output logic                                accel_out,
    output logic                                decel_out,
    output logic                                three_wire_out,
    // Process loop
    output logic                                loop_run_out,
    output logic                                loop_clear_out,
    // Speed loop
    output logic [2:0]                          gain_set_out,
    output logic                                p_only_out,
    output logic [16:0]                         droop_out,
    output logic                                droop_valid_out
);

    // Terminal conditioning
    difl_term_if term ();

    assign term.raw = {forward_run_input_in, term_in};

    difl_term_cond u_cond (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .term   (term.cond)
    );

    // Level of any terminal carrying a given function
    function automatic logic fn_level(
        input logic [DIFL_TERMS-1:0]      lvl,
        input logic [DIFL_TERMS-1:0][5:0] map,
        input logic [5:0]                 code
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < DIFL_TERMS; i++) begin
            if (map[i] == code && lvl[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    logic [DIFL_TERMS-1:0] gen_lvl;
    logic                  fwd_lvl;
    logic                  start_pulse_input;
    logic                  stop_hold_input;
    logic                  dir;
    logic                  rev;
    logic                  loff;
    logic                  lclr;
    logic                  galt;
    logic                  ponly;
    logic                  three_wire;
    logic                  method_ok;
    logic                  start_edge;

    // Function decode from debounced terminals; any general terminal may carry any code
    always_comb begin
        gen_lvl    = term.clean[DIFL_TERMS-1:0];
        fwd_lvl    = term.clean[DIFL_TERMS];
        start_pulse_input        = fn_level(gen_lvl, term_func_in, FN_START);
        stop_hold_input        = fn_level(gen_lvl, term_func_in, FN_STOP);          // Unassigned reads open
        dir        = fn_level(gen_lvl, term_func_in, FN_DIRECTION);
        rev        = fn_level(gen_lvl, term_func_in, FN_REVERSE);
        loff       = fn_level(gen_lvl, term_func_in, FN_LOOP_OFF);
        lclr       = fn_level(gen_lvl, term_func_in, FN_LOOP_CLEAR);
        galt       = fn_level(gen_lvl, term_func_in, FN_GAIN_ALT);
        ponly      = fn_level(gen_lvl, term_func_in, FN_P_ONLY);
        three_wire = (run_source_select_in == RUN_SRC_TERMINAL)
                     && fn_level('1, term_func_in, FN_START);
        method_ok  = (control_method_select_in == METHOD_SLV)
                     || (control_method_select_in == METHOD_ZERO_SLV)
                     || (control_method_select_in == METHOD_VECTOR);
    end

    // ---------------- Run control ----------------
    logic sta_prev_q;
    logic run_q;
    logic run_d;
    logic reverse_q;
    logic reverse_d;
    logic accel_q;
    logic accel_d;
    logic decel_q;
    logic decel_d;
    logic three_wire_q;

    assign start_edge = start_pulse_input && !sta_prev_q;

    // Next run state for three-wire or level control
    always_comb begin
        run_d     = 1'b0;
        reverse_d = 1'b0;
        if (three_wire) begin
            // Forward terminal and reverse inputs take no part here
            if (!stop_hold_input) begin
                run_d = 1'b0;
            end else if (start_edge) begin
                run_d = 1'b1;
            end else begin
                run_d = run_q;
            end
            reverse_d = dir;
        end else if (run_source_select_in == RUN_SRC_TERMINAL) begin
            // Level control: both on cancels to stop
            run_d     = fwd_lvl ^ rev;
            reverse_d = rev && !fwd_lvl;
        end
        accel_d = run_d && !run_q;
        decel_d = !run_d && run_q;
    end

    // Run state registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sta_prev_q   <= 1'b0;
            run_q        <= 1'b0;
            reverse_q    <= 1'b0;
            accel_q      <= 1'b0;
            decel_q      <= 1'b0;
            three_wire_q <= 1'b0;
        end else begin
            sta_prev_q   <= start_pulse_input;
            run_q        <= run_d;
            reverse_q    <= reverse_d;
            accel_q      <= accel_d;
            decel_q      <= decel_d;
            three_wire_q <= three_wire;
        end
    end

    // ---------------- Process loop ----------------
    logic loop_run_q;
    logic loop_run_d;
    logic loop_clear_q;
    logic loop_clear_d;

    // Disable terminal overrides the enable parameter
    always_comb begin
        loop_run_d   = (loop_enable_param_in == LOOP_ENABLED) && !loff;
        loop_clear_d = lclr;
    end

    // Loop control registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            loop_run_q   <= 1'b0;
            loop_clear_q <= 1'b0;
        end else begin
            loop_run_q   <= loop_run_d;
            loop_clear_q <= loop_clear_d;
        end
    end

    // ---------------- Speed-loop gains ----------------
    difl_gain_e gain_q;
    difl_gain_e gain_d;
    logic       p_only_q;
    logic       p_only_d;
    logic [9:0] kpp_sel;

    // Gain set and compensation type; alternate set and P-only in vector methods only, second set in any method
    always_comb begin
        if (method_ok && galt) begin
            gain_d = GAIN_ALT;
        end else if (second_motor_in) begin
            gain_d = GAIN_SECOND;
        end else begin
            gain_d = GAIN_PRIMARY;
        end
        p_only_d = method_ok && ponly;
        unique case (gain_d)
            GAIN_ALT:    kpp_sel = alternate_p_gain_in;
            GAIN_SECOND: kpp_sel = second_p_gain_in;
            default:     kpp_sel = primary_p_gain_in;
        endcase
    end

    // Gain registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            gain_q   <= GAIN_PRIMARY;
            p_only_q <= 1'b0;
        end else begin
            gain_q   <= gain_d;
            p_only_q <= p_only_d;
        end
    end

    // ---------------- Droop divider ----------------
    difl_div_e   div_q;
    difl_div_e   div_d;
    logic [4:0]  cnt_q;
    logic [4:0]  cnt_d;
    logic [16:0] num_q;
    logic [16:0] num_d;
    logic [16:0] quo_q;
    logic [16:0] quo_d;
    logic [9:0]  rem_q;
    logic [9:0]  rem_d;
    logic [9:0]  den_q;
    logic [9:0]  den_d;
    logic [16:0] droop_q;
    logic [16:0] droop_d;
    logic        seen_q;
    logic        seen_d;
    logic        valid_q;
    logic        valid_d;
    logic [9:0]  droop_gain_q;    // Gain that produced droop_q
    logic [9:0]  droop_gain_d;
    logic [10:0] trial;
    logic        take;

    // Restoring division of the droop numerator by the active gain;
    // a zero gain saturates the result to all ones
    always_comb begin
        div_d   = div_q;
        cnt_d   = cnt_q;
        num_d   = num_q;
        quo_d   = quo_q;
        rem_d   = rem_q;
        den_d   = den_q;
        droop_d = droop_q;
        seen_d  = seen_q;
        droop_gain_d = droop_gain_q;
        trial   = {rem_q, num_q[16]};
        take    = trial >= {1'b0, den_q};
        unique case (div_q)
            DIV_IDLE: begin
                div_d = DIV_BUSY;
                cnt_d = 5'h00;
                num_d = DROOP_NUMER;
                quo_d = '0;
                rem_d = '0;
                den_d = kpp_sel;
            end
            DIV_BUSY: begin
                num_d = {num_q[15:0], 1'b0};
                quo_d = {quo_q[15:0], take};
                rem_d = take ? 10'(trial - {1'b0, den_q}) : trial[9:0];
                cnt_d = 5'(cnt_q + 5'h01);
                if (cnt_q == DIV_LAST) begin
                    div_d   = DIV_IDLE;
                    droop_d = {quo_q[15:0], take};
                    droop_gain_d = den_q;
                    seen_d  = 1'b1;
                end
            end
            default: begin
                div_d = DIV_IDLE;
            end
        endcase
        // Valid only while the shown quotient was made from the gain now in use
        valid_d = p_only_d && seen_d && (droop_gain_d == kpp_sel);
    end

    // Divider registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            div_q   <= DIV_IDLE;
            cnt_q   <= 5'h00;
            num_q   <= '0;
            quo_q   <= '0;
            rem_q   <= '0;
            den_q   <= '0;
            droop_q <= DROOP_RESET;
            seen_q  <= 1'b0;
            valid_q <= 1'b0;
            droop_gain_q <= '0;
        end else begin
            div_q   <= div_d;
            cnt_q   <= cnt_d;
            num_q   <= num_d;
            quo_q   <= quo_d;
            rem_q   <= rem_d;
            den_q   <= den_d;
            droop_q <= droop_d;
            seen_q  <= seen_d;
            valid_q <= valid_d;
            droop_gain_q <= droop_gain_d;
        end
    end

    // Outputs straight from flip-flops
    assign run_out         = run_q;
    assign reverse_out     = reverse_q;
    assign accel_out       = accel_q;
    assign decel_out       = decel_q;
    assign three_wire_out  = three_wire_q;
    assign loop_run_out    = loop_run_q;
    assign loop_clear_out  = loop_clear_q;
    assign gain_set_out    = gain_q;
    assign p_only_out      = p_only_q;
    assign droop_out       = droop_q;
    assign droop_valid_out = valid_q;

    // ---------------- Checks ----------------
    sequence s_start_seen;
        three_wire && start_edge && stop_hold_input;
    endsequence

    sequence s_run_and_ramp;
        run_q && accel_q;
    endsequence

    a_start_runs_motor: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_start_seen and !run_q) |=> s_run_and_ramp)
        else $error("Start edge did not start the motor");

    a_stop_open_halts: assert property (@(posedge clk_in) disable iff (rst_in)
        three_wire && !stop_hold_input |=> !run_q && !accel_q)
        else $error("Open stop contact did not halt the motor");

    a_dir_follows_level: assert property (@(posedge clk_in) disable iff (rst_in)
        three_wire |=> reverse_q == $past(dir))
        else $error("Direction output did not follow its terminal");

    a_level_run_off: assert property (@(posedge clk_in) disable iff (rst_in)
        three_wire && !run_q && !start_edge |=> !run_q)
        else $error("Run began without a start edge in three-wire mode");

    a_hold_until_stop: assert property (@(posedge clk_in) disable iff (rst_in)
        three_wire && run_q && stop_hold_input |=> run_q)
        else $error("Run dropped while stop contact stayed closed");

    a_loop_run_gate: assert property (@(posedge clk_in) disable iff (rst_in)
        1'b1 |=> loop_run_q == ($past(loop_enable_param_in) == LOOP_ENABLED && !$past(loff)))
        else $error("Process loop run flag wrong");

    a_loop_clear_copy: assert property (@(posedge clk_in) disable iff (rst_in)
        lclr |=> loop_clear_q)
        else $error("Integrator clear not issued");

    a_gain_alt_pick: assert property (@(posedge clk_in) disable iff (rst_in)
        method_ok && galt |=> gain_q == GAIN_ALT)
        else $error("Alternate gain set not selected");

    a_gain_off_pick: assert property (@(posedge clk_in) disable iff (rst_in)
        !(method_ok && galt) |=> gain_q != GAIN_ALT)
        else $error("Alternate gain set used without switch or vector method");

    a_p_only_pick: assert property (@(posedge clk_in) disable iff (rst_in)
        1'b1 |=> p_only_q == ($past(method_ok) && $past(ponly)))
        else $error("P or PI selection wrong");

    a_droop_value: assert property (@(posedge clk_in) disable iff (rst_in)
        div_q == DIV_BUSY && cnt_q == 5'h00 |-> ##17
        droop_q == ((den_q == 10'h000) ? 17'h1_ffff : 17'(DROOP_NUMER / den_q)))
        else $error("Droop quotient wrong");

endmodule

// ---- rtl/difl_pkg.sv ----
// Constants, encodings and types for the drive input function logic.
// Assumes one system clock and a synchronous power-up reset.
package difl_pkg;

    // Terminal counts
    localparam int          DIFL_TERMS      = 8;
    localparam int          DIFL_LINES      = 9;       // Eight general terminals plus forward

    // Terminal function codes
    localparam logic [5:0]  FN_REVERSE      = 6'h01;
    localparam logic [5:0]  FN_START        = 6'h14;
    localparam logic [5:0]  FN_STOP         = 6'h15;
    localparam logic [5:0]  FN_DIRECTION    = 6'h16;
    localparam logic [5:0]  FN_LOOP_OFF     = 6'h17;
    localparam logic [5:0]  FN_LOOP_CLEAR   = 6'h18;
    localparam logic [5:0]  FN_GAIN_ALT     = 6'h1a;
    localparam logic [5:0]  FN_P_ONLY       = 6'h2b;

    // Parameter values
    localparam logic [1:0]  RUN_SRC_TERMINAL = 2'h1;
    localparam logic [1:0]  LOOP_ENABLED     = 2'h1;
    localparam logic [2:0]  METHOD_SLV       = 3'h3;
    localparam logic [2:0]  METHOD_ZERO_SLV  = 3'h4;
    localparam logic [2:0]  METHOD_VECTOR    = 3'h5;

    // Droop numerator: ten percent scaled to hundredths of percent over gain in hundredths
    localparam logic [16:0] DROOP_NUMER      = 17'h1_86a0;
    localparam logic [4:0]  DIV_LAST         = 5'h10;    // Seventeen quotient steps

    // Reset values
    localparam logic [16:0] DROOP_RESET      = 17'h0_0000;

    // Speed-loop gain set in use
    typedef enum logic [2:0] {
        GAIN_PRIMARY = 3'b001,
        GAIN_SECOND  = 3'b010,
        GAIN_ALT     = 3'b100
    } difl_gain_e;

    // Droop divider states
    typedef enum logic [1:0] {
        DIV_IDLE = 2'b01,
        DIV_BUSY = 2'b10
    } difl_div_e;

endpackage

// ---- rtl/difl_term_if.sv ----
// Carrier between the decoder core and its terminal conditioner.
// Assumes both ends share the system clock.
`timescale 1ns/100ps
interface difl_term_if;
    import difl_pkg::*;

    logic [DIFL_LINES-1:0] raw;     // Terminal levels straight from the pins
    logic [DIFL_LINES-1:0] clean;   // Synchronised and debounced levels

    modport cond (input raw, output clean);
    modport core (output raw, input clean);
endinterface

// ---- rtl/difl_term_cond.sv ----
// Terminal conditioner: three-stage synchroniser with agreement debounce.
// Assumes raw levels are asynchronous to clk_in.
`timescale 1ns/100ps
module difl_term_cond
    import difl_pkg::*;
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // Terminal carrier
    difl_term_if.cond term
);

    logic [DIFL_LINES-1:0] ff1_q;
    logic [DIFL_LINES-1:0] ff2_q;
    logic [DIFL_LINES-1:0] ff3_q;
    logic [DIFL_LINES-1:0] clean_q;
    logic [DIFL_LINES-1:0] clean_d;

    // Clean level moves only when the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < DIFL_LINES; gi++) begin : g_line
            always_comb begin
                clean_d[gi] = (ff2_q[gi] == ff3_q[gi]) ? ff3_q[gi] : clean_q[gi];
            end
        end
    endgenerate

    // Synchroniser chain and debounced level
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ff1_q   <= '0;
            ff2_q   <= '0;
            ff3_q   <= '0;
            clean_q <= '0;
        end else begin
            ff1_q   <= term.raw;
            ff2_q   <= ff1_q;
            ff3_q   <= ff2_q;
            clean_q <= clean_d;
        end
    end

    assign term.clean = clean_q;

    a_clean_needs_agree: assert property (@(posedge clk_in) disable iff (rst_in)
        ((clean_q ^ $past(clean_q)) & ($past(ff2_q) ^ $past(ff3_q))) == '0)
        else $error("Clean level moved without stage agreement");

endmodule

// ---- verif/difl_contact_model.sv ----
// Contact model: switches and relay contacts wired to the drive terminals.
// Assumes the bench calls its tasks; contacts move just after a clock edge.
`timescale 1ns/100ps
module difl_contact_model (
    // Clock
    input  wire logic  clk_in,
    // Contact levels, 1 = closed
    output logic [7:0] term_out,
    output logic       fwd_out
);
    // Contacts start open
    initial begin
        term_out = 8'h00;
        fwd_out  = 1'b0;
    end

    // Open or close one momentary or selector contact
    task automatic set_term(input int idx, input logic lvl);
        @(posedge clk_in);
        term_out[idx] <= lvl;
    endtask

    // Level-type forward run contact
    task automatic set_fwd(input logic lvl);
        @(posedge clk_in);
        fwd_out <= lvl;
    endtask
endmodule

// ---- verif/tb_top.sv ----
// Testbench for the drive input function logic.
// Assumes the contact model drives the pins; parameters driven here.
`timescale 1ns/100ps
module tb_top;
    import difl_pkg::*;
    logic                       clk_in, rst_in, fwd, sec;
    logic                       run, rev, acc, dec, tw, lrun, lclr, ponly, dv;
    logic [7:0]                 pins;
    logic [DIFL_TERMS-1:0][5:0] fn;
    logic [1:0]                 src, len;
    logic [2:0]                 meth, gset;
    logic [9:0]                 g1, g2, g3;
    logic [16:0]                droop;
    int                         n_mismatch, compares;

    difl_contact_model u_con (.clk_in(clk_in), .term_out(pins), .fwd_out(fwd));

    difl_core dut (
        .clk_in(clk_in), .rst_in(rst_in), .term_in(pins), .forward_run_input_in(fwd),
        .term_func_in(fn), .run_source_select_in(src), .loop_enable_param_in(len),
        .control_method_select_in(meth), .second_motor_in(sec),
        .primary_p_gain_in(g1), .second_p_gain_in(g2), .alternate_p_gain_in(g3),
        .run_out(run), .reverse_out(rev), .accel_out(acc), .decel_out(dec),
        .three_wire_out(tw), .loop_run_out(lrun), .loop_clear_out(lclr),
        .gain_set_out(gset), .p_only_out(ponly), .droop_out(droop),
        .droop_valid_out(dv)
    );

    // 50 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic finish_test();
        $display("Compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // Wait for run to reach lvl, then expect the matching ramp pulse
    task automatic wait_run(input logic lvl);
        for (int i = 0; i < 20; i++) begin
            tick(1);
            if (run === lvl) begin
                chk("ramp pulse", 17'h0_0001, 17'(lvl ? acc : dec));
                tick(1);
                chk("ramp pulse end", 17'h0_0000, 17'(lvl ? acc : dec));
                return;
            end
        end
        chk("run level", 17'(lvl), 17'(run));
        finish_test();
    endtask

    // Wait for a fresh droop result and compare it
    task automatic chk_droop(input logic [16:0] exp);
        tick(8);
        for (int i = 0; i < 60 && dv !== 1'b1; i++) begin
            tick(1);
        end
        chk("droop valid", 17'h0_0001, 17'(dv));
        if (dv !== 1'b1) begin
            finish_test();
        end else begin
            chk("droop", exp, droop);
        end
    endtask

    // Start, stop, direction and ignored level inputs
    task automatic test_three_wire();
        u_con.set_term(1, 1'b1);
        u_con.set_fwd(1'b1);
        u_con.set_term(7, 1'b1);
        tick(8);
        chk("three wire", 17'h0_0001, 17'(tw));
        chk("run fwd ignored", 17'h0_0000, 17'(run));
        u_con.set_fwd(1'b0);
        u_con.set_term(7, 1'b0);
        u_con.set_term(0, 1'b1);
        wait_run(1'b1);
        u_con.set_term(0, 1'b0);
        tick(8);
        chk("run latched", 17'h0_0001, 17'(run));
        u_con.set_term(2, 1'b1);
        tick(8);
        chk("reverse", 17'h0_0001, 17'(rev));
        u_con.set_term(2, 1'b0);
        tick(8);
        chk("forward", 17'h0_0000, 17'(rev));
        u_con.set_term(1, 1'b0);
        wait_run(1'b0);
        u_con.set_term(0, 1'b1);
        tick(8);
        chk("start while stopped", 17'h0_0000, 17'(run));
        u_con.set_term(0, 1'b0);
        u_con.set_term(1, 1'b1);
        @(posedge clk_in);
        src <= 2'h0;
        tick(3);
        chk("three wire off", 17'h0_0000, 17'(tw));
        @(posedge clk_in);
        src <= RUN_SRC_TERMINAL;
    endtask

    // Loop enable, disable and clear, motor held stopped
    task automatic test_loop();
        @(posedge clk_in);
        len <= LOOP_ENABLED;
        tick(3);
        chk("loop run", 17'h0_0001, 17'(lrun));
        u_con.set_term(3, 1'b1);
        tick(8);
        chk("loop disabled", 17'h0_0000, 17'(lrun));
        u_con.set_term(3, 1'b0);
        u_con.set_term(4, 1'b1);
        tick(8);
        chk("loop rerun", 17'h0_0001, 17'(lrun));
        chk("loop clear", 17'h0_0001, 17'(lclr));
        u_con.set_term(4, 1'b0);
        @(posedge clk_in);
        len <= 2'h2;
        tick(8);
        chk("loop param off", 17'h0_0000, 17'(lrun));
        chk("clear released", 17'h0_0000, 17'(lclr));
    endtask

    // Gain set and P/PI selection across every control method
    task automatic test_gain();
        u_con.set_term(5, 1'b1);
        u_con.set_term(6, 1'b1);
        for (int m = 0; m < 8; m++) begin
            @(posedge clk_in);
            meth <= 3'(m);
            tick(8);
            chk("gain set", (m > 2 && m < 6) ? 17'h0_0004 : 17'h0_0001, 17'(gset));
            chk("p only", 17'(m > 2 && m < 6), 17'(ponly));
        end
        @(posedge clk_in);
        meth <= METHOD_ZERO_SLV;
        fn[5] <= 6'h00;
        tick(3);
        chk("gain unassigned", 17'h0_0001, 17'(gset));
        @(posedge clk_in);
        fn[5] <= FN_GAIN_ALT;
        sec <= 1'b1;
        tick(3);
        chk("gain alt", 17'h0_0004, 17'(gset));
        u_con.set_term(5, 1'b0);
        tick(8);
        chk("gain second", 17'h0_0002, 17'(gset));
        @(posedge clk_in);
        sec <= 1'b0;
        u_con.set_term(6, 1'b0);
        tick(8);
        chk("gain primary", 17'h0_0001, 17'(gset));
        chk("pi mode", 17'h0_0000, 17'(ponly));
    endtask

    // Droop for primary and alternate proportional gains
    task automatic test_droop();
        u_con.set_term(6, 1'b1);
        chk_droop(17'h0_03e8);
        @(posedge clk_in);
        g1 <= 10'h3e8;
        chk_droop(17'h0_0064);
        u_con.set_term(5, 1'b1);
        chk_droop(17'h0_01f4);
    endtask

    // P/PI select placed on each general terminal in turn
    task automatic test_any_term();
        logic [DIFL_TERMS-1:0][5:0] map;
        u_con.set_term(5, 1'b0);
        u_con.set_term(6, 1'b0);
        for (int i = 0; i < DIFL_TERMS; i++) begin
            map = '0;
            map[i] = FN_P_ONLY;
            @(posedge clk_in);
            fn <= map;
            u_con.set_term(i, 1'b1);
            tick(8);
            chk("p only terminal", 17'h0_0001, 17'(ponly));
            u_con.set_term(i, 1'b0);
            tick(8);
            chk("p only terminal off", 17'h0_0000, 17'(ponly));
        end
    endtask

    // Main sequence
    initial begin
        n_mismatch = 0;
        compares = 0;
        rst_in = 1'b1;
        fn = {FN_REVERSE, FN_P_ONLY, FN_GAIN_ALT, FN_LOOP_CLEAR,
              FN_LOOP_OFF, FN_DIRECTION, FN_STOP, FN_START};
        src = RUN_SRC_TERMINAL;
        len = 2'h0;
        meth = 3'h0;
        sec = 1'b0;
        g1 = 10'h064;
        g2 = 10'h032;
        g3 = 10'h0c8;
        tick(10);
        chk("reset gain", 17'h0_0001, 17'(gset));
        chk("reset run", 17'h0_0000, 17'({run, tw, lrun, ponly, dv}));
        @(posedge clk_in);
        rst_in <= 1'b0;
        test_three_wire();
        test_loop();
        test_gain();
        test_droop();
        test_any_term();
        finish_test();
    end
endmodule
